// [mie_consts.svh]
// Offsets, field positions, reset values and timing counts of the move unit
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH
`define MIE_OFF_INSTR    8'h00
`define MIE_OFF_ACC      8'h04
`define MIE_OFF_BANK     8'h08
`define MIE_OFF_PCLATCH  8'h0C
`define MIE_OFF_PTR0     8'h10
`define MIE_OFF_PTR1     8'h14
`define MIE_OFF_STATUS   8'h18
`define MIE_OFF_WIN0     8'h1C
`define MIE_OFF_WIN1     8'h20
`define MIE_OP_MSB       15
`define MIE_OP_LSB       12
`define MIE_PSEL_BIT     8
`define MIE_REL_BIT      7
`define MIE_MODE_MSB     1
`define MIE_MODE_LSB     0
`define MIE_K_MSB        5
`define MIE_K_LSB        0
`define MIE_LIT_MSB      7
`define MIE_LIT_LSB      0
`define MIE_BANK_W       5
`define MIE_LATCH_W      7
`define MIE_STAT_ZERO    0
`define MIE_STAT_BUSY    1
`define MIE_RST_ACC      8'h00
`define MIE_RST_BANK     5'h00
`define MIE_RST_LATCH    7'h00
`define MIE_RST_PTR      16'h0000
`define MIE_RST_INSTR    16'h0000
`define MIE_MEM_RD_LAT   1
`endif

// [mie_pkg.sv]
// Types of the move unit: controller states, opcodes and pointer modes
package mie_pkg;
    typedef enum logic [2:0] {
        MIE_ST_IDLE    = 3'h0,
        MIE_ST_RD_WAIT = 3'h1,
        MIE_ST_RD_CAP  = 3'h2,
        MIE_ST_ACK     = 3'h3
    } mie_state_t;
    typedef enum logic [3:0] {
        MIE_OP_NOP        = 4'h0,
        MIE_OP_LOAD_IND   = 4'h1,
        MIE_OP_STORE_IND  = 4'h2,
        MIE_OP_LIT_BANK   = 4'h3,
        MIE_OP_LIT_LATCH  = 4'h4,
        MIE_OP_LIT_ACC    = 4'h5,
        MIE_OP_ACC_FILE   = 4'h6
    } mie_op_t;
    typedef enum logic [1:0] {
        MIE_MODE_PRE_INC  = 2'h0,
        MIE_MODE_PRE_DEC  = 2'h1,
        MIE_MODE_POST_INC = 2'h2,
        MIE_MODE_POST_DEC = 2'h3
    } mie_mode_t;
endpackage

// [mie_move_exec.sv]
// Move instruction execution unit with classic Wishbone register access
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`include "mie_consts.svh"

module mie_move_exec (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             mem_we,
    output logic             mem_re,
    input  wire logic [7:0]  mem_rdata,
    output logic      [6:0]  file_addr,
    output logic      [7:0]  file_wdata,
    output logic             file_we,
    output logic      [7:0]  acc_out,
    output logic             zero_flag,
    output logic      [4:0]  bank_select_reg,
    output logic      [6:0]  pc_high_latch
);
    mie_pkg::mie_state_t state_reg;
    mie_pkg::mie_state_t state_next;
    logic [7:0]  acc_reg;
    logic        zero_reg;
    logic [4:0]  bank_reg;
    logic [6:0]  latch_reg;
    logic [15:0] instr_reg;
    logic [15:0] ptr_reg [2];
    logic        rd_to_acc_reg;
    logic [31:0] dat_reg;
    logic [15:0] maddr_reg;
    logic [7:0]  mwdata_reg;
    logic        mwe_reg;
    logic        mre_reg;
    logic [6:0]  faddr_reg;
    logic [7:0]  fwdata_reg;
    logic        fwe_reg;

    logic        req;
    logic        wr;
    logic        rd;
    logic [15:0] iw;
    mie_pkg::mie_op_t   op;
    mie_pkg::mie_mode_t mode;
    logic        psel;
    logic        rel;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;
    logic [15:0] offset;
    logic [15:0] eff_addr;
    logic [15:0] ptr_new;
    logic        exec;
    logic        exec_load;
    logic        exec_store;
    logic        win_hit;
    logic        win_sel;

    function automatic logic hit(input logic [31:0] adr, input logic [7:0] off);
        hit = (adr[31:8] == 24'h000000) && (adr[7:0] == off);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // Bus requests are taken only while the controller is idle
    assign req = wb_cyc_i && wb_stb_i && (state_reg == mie_pkg::MIE_ST_IDLE);
    assign wr  = req && wb_we_i;
    assign rd  = req && !wb_we_i;

    assign iw      = wb_dat_i[15:0];
    assign op      = mie_pkg::mie_op_t'(iw[`MIE_OP_MSB:`MIE_OP_LSB]);
    assign mode    = mie_pkg::mie_mode_t'(iw[`MIE_MODE_MSB:`MIE_MODE_LSB]);
    assign psel    = iw[`MIE_PSEL_BIT];
    assign rel     = iw[`MIE_REL_BIT];
    assign ptr_cur = ptr_reg[psel];
    // Sixteen-bit arithmetic wraps at both ends by construction
    assign ptr_inc = ptr_cur + 16'h0001;
    assign ptr_dec = ptr_cur - 16'h0001;
    assign offset  = {{10{iw[`MIE_K_MSB]}}, iw[`MIE_K_MSB:`MIE_K_LSB]};

    assign exec       = wr && hit(wb_adr_i, `MIE_OFF_INSTR) && wb_sel_i[0] && wb_sel_i[1];
    assign exec_load  = exec && (op == mie_pkg::MIE_OP_LOAD_IND);
    assign exec_store = exec && (op == mie_pkg::MIE_OP_STORE_IND);
    assign win_hit    = hit(wb_adr_i, `MIE_OFF_WIN0) || hit(wb_adr_i, `MIE_OFF_WIN1);
    assign win_sel    = hit(wb_adr_i, `MIE_OFF_WIN1);

    always_comb begin
        eff_addr = ptr_cur;
        ptr_new  = ptr_cur;
        if (rel) begin
            eff_addr = ptr_cur + offset;
        end else begin
            unique case (mode)
                mie_pkg::MIE_MODE_PRE_INC: begin
                    eff_addr = ptr_inc;
                    ptr_new  = ptr_inc;
                end
                mie_pkg::MIE_MODE_PRE_DEC: begin
                    eff_addr = ptr_dec;
                    ptr_new  = ptr_dec;
                end
                mie_pkg::MIE_MODE_POST_INC: begin
                    ptr_new = ptr_inc;
                end
                mie_pkg::MIE_MODE_POST_DEC: begin
                    ptr_new = ptr_dec;
                end
            endcase
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            mie_pkg::MIE_ST_IDLE: begin
                if (exec_load || (rd && win_hit)) begin
                    state_next = mie_pkg::MIE_ST_RD_WAIT;
                end else if (req) begin
                    state_next = mie_pkg::MIE_ST_ACK;
                end
            end
            mie_pkg::MIE_ST_RD_WAIT: state_next = mie_pkg::MIE_ST_RD_CAP;
            mie_pkg::MIE_ST_RD_CAP:  state_next = mie_pkg::MIE_ST_ACK;
            mie_pkg::MIE_ST_ACK:     state_next = mie_pkg::MIE_ST_IDLE;
            default:                 state_next = mie_pkg::MIE_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= mie_pkg::MIE_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_to_acc_reg <= 1'b0;
        end else if (req) begin
            rd_to_acc_reg <= exec_load;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            instr_reg <= `MIE_RST_INSTR;
        end else if (exec) begin
            instr_reg <= iw;
        end
    end

    // Accumulator and zero flag; only the indirect load and a status write touch zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            acc_reg  <= `MIE_RST_ACC;
            zero_reg <= 1'b0;
        end else if (state_reg == mie_pkg::MIE_ST_RD_CAP && rd_to_acc_reg) begin
            acc_reg  <= mem_rdata;
            zero_reg <= (mem_rdata == 8'h00);
        end else if (exec && op == mie_pkg::MIE_OP_LIT_ACC) begin
            acc_reg <= iw[`MIE_LIT_MSB:`MIE_LIT_LSB];
        end else if (wr && hit(wb_adr_i, `MIE_OFF_ACC) && wb_sel_i[0]) begin
            acc_reg <= wb_dat_i[7:0];
        end else if (wr && hit(wb_adr_i, `MIE_OFF_STATUS) && wb_sel_i[0]) begin
            zero_reg <= wb_dat_i[`MIE_STAT_ZERO];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bank_reg <= `MIE_RST_BANK;
        end else if (exec && op == mie_pkg::MIE_OP_LIT_BANK) begin
            bank_reg <= iw[`MIE_BANK_W-1:0];
        end else if (wr && hit(wb_adr_i, `MIE_OFF_BANK) && wb_sel_i[0]) begin
            bank_reg <= wb_dat_i[`MIE_BANK_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            latch_reg <= `MIE_RST_LATCH;
        end else if (exec && op == mie_pkg::MIE_OP_LIT_LATCH) begin
            latch_reg <= iw[`MIE_LATCH_W-1:0];
        end else if (wr && hit(wb_adr_i, `MIE_OFF_PCLATCH) && wb_sel_i[0]) begin
            latch_reg <= wb_dat_i[`MIE_LATCH_W-1:0];
        end
    end

    // The two pointers differ only in their offset and select value
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        localparam logic [7:0] PTR_OFF = (i == 0) ? `MIE_OFF_PTR0 : `MIE_OFF_PTR1;
        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                ptr_reg[i] <= `MIE_RST_PTR;
            end else if ((exec_load || exec_store) && psel == 1'(i) && !rel) begin
                ptr_reg[i] <= ptr_new;
            end else if (wr && hit(wb_adr_i, PTR_OFF)) begin
                ptr_reg[i] <= merge16(ptr_reg[i], wb_dat_i, wb_sel_i);
            end
        end
    end

    // Memory port is registered, so the memory sees the request one cycle later
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            maddr_reg  <= 16'h0000;
            mwdata_reg <= 8'h00;
            mwe_reg    <= 1'b0;
            mre_reg    <= 1'b0;
        end else begin
            mwe_reg <= 1'b0;
            mre_reg <= 1'b0;
            if (exec_load || exec_store) begin
                maddr_reg  <= eff_addr;
                mwdata_reg <= acc_reg;
                mwe_reg    <= exec_store;
                mre_reg    <= exec_load;
            end else if (req && win_hit) begin
                maddr_reg  <= ptr_reg[win_sel];
                mwdata_reg <= wb_dat_i[7:0];
                mwe_reg    <= wb_we_i && wb_sel_i[0];
                mre_reg    <= !wb_we_i;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            faddr_reg  <= 7'h00;
            fwdata_reg <= 8'h00;
            fwe_reg    <= 1'b0;
        end else begin
            fwe_reg <= 1'b0;
            if (exec && op == mie_pkg::MIE_OP_ACC_FILE) begin
                faddr_reg  <= iw[6:0];
                fwdata_reg <= acc_reg;
                fwe_reg    <= 1'b1;
            end
        end
    end

    // Read data; unmapped offsets and writes read back as zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dat_reg <= 32'h00000000;
        end else if (state_reg == mie_pkg::MIE_ST_RD_CAP) begin
            dat_reg <= rd_to_acc_reg ? 32'h00000000 : {24'h000000, mem_rdata};
        end else if (rd) begin
            dat_reg <= 32'h00000000;
            if (hit(wb_adr_i, `MIE_OFF_INSTR)) begin
                dat_reg <= {16'h0000, instr_reg};
            end
            if (hit(wb_adr_i, `MIE_OFF_ACC)) begin
                dat_reg <= {24'h000000, acc_reg};
            end
            if (hit(wb_adr_i, `MIE_OFF_BANK)) begin
                dat_reg <= {27'h0000000, bank_reg};
            end
            if (hit(wb_adr_i, `MIE_OFF_PCLATCH)) begin
                dat_reg <= {25'h0000000, latch_reg};
            end
            if (hit(wb_adr_i, `MIE_OFF_PTR0)) begin
                dat_reg <= {16'h0000, ptr_reg[0]};
            end
            if (hit(wb_adr_i, `MIE_OFF_PTR1)) begin
                dat_reg <= {16'h0000, ptr_reg[1]};
            end
            if (hit(wb_adr_i, `MIE_OFF_STATUS)) begin
                dat_reg <= {30'h00000000, 1'b0, zero_reg};
            end
        end else if (state_reg == mie_pkg::MIE_ST_ACK) begin
            dat_reg <= 32'h00000000;
        end
    end

    assign wb_ack_o        = (state_reg == mie_pkg::MIE_ST_ACK);
    assign wb_dat_o        = dat_reg;
    assign mem_addr        = maddr_reg;
    assign mem_wdata       = mwdata_reg;
    assign mem_we          = mwe_reg;
    assign mem_re          = mre_reg;
    assign file_addr       = faddr_reg;
    assign file_wdata      = fwdata_reg;
    assign file_we         = fwe_reg;
    assign acc_out         = acc_reg;
    assign zero_flag       = zero_reg;
    assign bank_select_reg = bank_reg;
    assign pc_high_latch   = latch_reg;
endmodule

// [mie_move_exec_checker.sv]
// Concurrent checks on the move unit ports
module mie_move_exec_checker (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_we,
    input wire logic        mem_re,
    input wire logic [7:0]  mem_rdata,
    input wire logic [6:0]  file_addr,
    input wire logic [7:0]  file_wdata,
    input wire logic        file_we,
    input wire logic [7:0]  acc_out,
    input wire logic        zero_flag,
    input wire logic [4:0]  bank_select_reg,
    input wire logic [6:0]  pc_high_latch
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Instruction write in its taking cycle and, for an indirect load, both wait cycles; ack low keeps the answer cycle out
    logic       go;
    logic [3:0] op;
    assign go = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 32'h0 && wb_sel_i[1:0] == 2'b11
                && !wb_ack_o;
    assign op = wb_dat_i[15:12];
    a_lit_acc_load:
        assert property (go && op == 4'h5 |=> wb_ack_o && acc_out == $past(wb_dat_i[7:0])
            && $stable(zero_flag)) else $error("literal to accumulator wrong");
    a_lit_bank_load:
        assert property (go && op == 4'h3 |=> bank_select_reg == $past(wb_dat_i[4:0])
            && $stable(zero_flag)) else $error("literal to bank wrong");
    a_lit_latch_load:
        assert property (go && op == 4'h4 |=> pc_high_latch == $past(wb_dat_i[6:0])
            && $stable(zero_flag)) else $error("literal to latch wrong");
    a_file_write_once:
        assert property (go && op == 4'h6 |=> file_we && wb_ack_o && file_wdata == acc_out
            && file_addr == $past(wb_dat_i[6:0]) ##1 !file_we) else $error("file write wrong");
    a_store_acc_data:
        assert property (mem_we && wb_adr_i == 32'h0 |-> mem_wdata == acc_out
            && $stable(zero_flag)) else $error("store data wrong");
    a_store_one_cycle:
        assert property (mem_we |-> wb_ack_o ##1 !mem_we) else $error("store pulse wrong");
    a_load_acc_zero:
        assert property (mem_re && go && op == 4'h1 |-> ##2 wb_ack_o
            && acc_out == $past(mem_rdata) && zero_flag == (acc_out == 8'h00))
            else $error("indirect load wrong");
    a_step_no_flag:
        assert property (mem_re |-> $stable(zero_flag) ##1 $stable(zero_flag))
            else $error("flag moved during pointer step");
    a_window_read_data:
        assert property (mem_re && wb_adr_i != 32'h0 |-> ##2 wb_ack_o
            && wb_dat_o[7:0] == $past(mem_rdata)) else $error("window read wrong");
endmodule

bind mie_move_exec mie_move_exec_checker u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata), .file_addr(file_addr), .file_wdata(file_wdata),
    .file_we(file_we), .acc_out(acc_out), .zero_flag(zero_flag),
    .bank_select_reg(bank_select_reg), .pc_high_latch(pc_high_latch));

// [mie_mem_model.sv]
// Data memory partner with one-cycle read latency
module mie_mem_model (
    input wire logic        sys_clk,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_we,
    input wire logic        mem_re,
    output logic     [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    initial mem_rdata = 8'h00;
    // Outside the data cycle the bus toggles so stale data cannot pass
    always @(posedge sys_clk) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (mem_re) mem_rdata <= mem[mem_addr];
        else mem_rdata <= ~mem_rdata;
    end
endmodule

// [test_move_instruction_exec.sv]
// Self-checking bench for the move unit
`include "mie_consts.svh"
module test_move_instruction_exec;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, rst_b = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'hF;
    logic        wb_ack_o, mem_we, mem_re, file_we, zero_flag;
    logic [15:0] mem_addr, start, nxt, eff;
    logic [7:0]  mem_wdata, mem_rdata, file_wdata, acc_out, val, f_data;
    logic [6:0]  file_addr, pc_high_latch, f_addr;
    logic [4:0]  bank_select_reg;
    logic [31:0] pa;
    int          n_mismatch = 0;
    int          num_checks = 0;
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (file_we === 1'b1) {f_addr, f_data} = {file_addr, file_wdata};
    mie_move_exec DUT (.sys_clk(sys_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
        .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we), .acc_out(acc_out),
        .zero_flag(zero_flag), .bank_select_reg(bank_select_reg),
        .pc_high_latch(pc_high_latch));
    mie_mem_model u_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic [31:0] a, input logic we, input logic [31:0] d);
        int n;
        int lat;
        n = 0;
        // Indirect load and window read answer in cycle 4, everything else in cycle 2
        lat = ((!we && (a == `MIE_OFF_WIN0 || a == `MIE_OFF_WIN1))
              || (we && a == `MIE_OFF_INSTR && d[15:12] == 4'h1)) ? 4 : 2;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        check("ack cycles", lat, n);
        // Look at outputs and the memory only once the ack edge has settled
        @(negedge sys_clk);
    endtask
    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        check(what, exp, rd);
    endtask
    task automatic exec(input logic [3:0] op, input logic n, input logic rel, input logic [7:0] f);
        wb(`MIE_OFF_INSTR, 1'b1, {16'h0, op, 3'b000, n, rel ? {1'b1, 1'b0, f[5:0]} : f});
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk("reset reg", 32'(i * 4 + 4), 32'h0);
        $display("Test reset done");
        wb(`MIE_OFF_STATUS, 1'b1, 32'h1);
        exec(4'h5, 1'b0, 1'b0, 8'hA5);
        check("acc", 32'hA5, acc_out);
        exec(4'h3, 1'b0, 1'b0, 8'hFF);
        check("bank", 32'h1F, bank_select_reg);
        exec(4'h4, 1'b0, 1'b0, 8'hFF);
        check("latch", 32'h7F, pc_high_latch);
        exec(4'h6, 1'b0, 1'b0, 8'hFF);
        check("file write", {17'h0, 7'h7F, 8'hA5}, {17'h0, f_addr, f_data});
        rdchk("zero flag", `MIE_OFF_STATUS, 32'h1);
        wb(32'h40, 1'b1, 32'hFF);
        rdchk("unmapped", 32'h40, 32'h0);
        $display("Test literals done");
        for (int m = 0; m < 4; m++) begin
            start = m[0] ? 16'h0000 : 16'hFFFF;
            nxt = ~start;
            eff = m[1] ? start : nxt;
            pa = m[0] ? `MIE_OFF_PTR1 : `MIE_OFF_PTR0;
            val = 8'(8'h30 + m);
            exec(4'h5, 1'b0, 1'b0, val);
            wb(pa, 1'b1, {16'h0, start});
            exec(4'h2, m[0], 1'b0, 8'(m));
            check("stored byte", val, u_mem.mem[eff]);
            rdchk("ptr after store", pa, nxt);
            wb(pa, 1'b1, {16'h0, start});
            wb(`MIE_OFF_STATUS, 1'b1, 32'h1);
            exec(4'h5, 1'b0, 1'b0, 8'h00);
            exec(4'h1, m[0], 1'b0, 8'(m));
            check("loaded acc", {24'h0, val}, {24'h0, acc_out});
            check("zero after load", 32'h0, zero_flag);
            rdchk("ptr after load", pa, nxt);
        end
        $display("Test pointer modes done");
        for (int j = 0; j < 2; j++) begin
            eff = j ? 16'h002F : 16'hFFF0;
            val = j ? 8'h99 : 8'h00;
            wb(`MIE_OFF_PTR1, 1'b1, 32'h10);
            exec(4'h5, 1'b0, 1'b0, val);
            exec(4'h2, 1'b1, 1'b1, j ? 8'h1F : 8'h20);
            check("rel store", val, u_mem.mem[eff]);
            exec(4'h5, 1'b0, 1'b0, 8'h55);
            exec(4'h1, 1'b1, 1'b1, j ? 8'h1F : 8'h20);
            check("rel load", {23'h0, val == 8'h0, val}, {23'h0, zero_flag, acc_out});
            rdchk("rel ptr", `MIE_OFF_PTR1, 32'h10);
        end
        $display("Test relative done");
        wb(`MIE_OFF_PTR0, 1'b1, 32'h1234);
        wb(`MIE_OFF_WIN0, 1'b1, 32'h77);
        check("window write", 8'h77, u_mem.mem[16'h1234]);
        wb(`MIE_OFF_PTR1, 1'b1, 32'h2F);
        rdchk("window read", `MIE_OFF_WIN1, 32'h99);
        rdchk("window ptr", `MIE_OFF_PTR0, 32'h1234);
        $display("Test window done");
        tally_and_finish;
    end
endmodule
